// *** design/clk_align_consts.vh ***
// Constants for the clock and alignment control register bank
`ifndef CLK_ALIGN_CONSTS_VH
`define CLK_ALIGN_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_W 8
`define OFS_SYSREF_PATH_CONTROL 8'h29
`define OFS_INPUT_MODE_CONTROL 8'h2a
`define OFS_SUPPLY_NOISE_CONTROL 8'h2b
`define OFS_CAPTURE_POS_LO 8'h2c
`define OFS_CAPTURE_POS_MID 8'h2d
`define OFS_CAPTURE_POS_HI 8'h2e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SYSREF_PATH_CONTROL 8'h80
`define RST_INPUT_MODE_CONTROL 8'h00
`define RST_SUPPLY_NOISE_CONTROL 8'h10
`define RST_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_PROCESSOR_ON 6
`define BIT_RECEIVER_ON 5
`define BIT_FINE_STEP 4
`define TAP_MSB 3
`define TAP_LSB 0
`define BIT_MAIN_CLK_PECL 2
`define BIT_ALIGN_PECL 1
`define BIT_POL_INVERT 0
`define BIT_CORE_QUIET 2
`define BIT_CLOCK_QUIET 0
`define CAPTURE_POS_W 24

`endif

// *** design/ctrl_byte_reg.v ***
// One 8-bit read/write control register with a parameterised reset value
`timescale 1ns/1ps
module ctrl_byte_reg
#(
  parameter [7:0] RESET_VAL = 8'h00
)
(
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Write port
  input wire wr_sel,
  input wire [7:0] wr_data,
  // Stored value
  output wire [7:0] value
);

  reg [7:0] value_ff;
  reg [7:0] nxt_value;

  always @*
  begin
    nxt_value = value_ff;
    if (wr_sel)
    begin
      // Whole byte is stored, reserved bits included, so reads echo writes
      nxt_value = wr_data;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      value_ff <= RESET_VAL;
    end
    else
    begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

endmodule // ctrl_byte_reg

// *** design/clock_alignment_control_regs.v ***
// Clock and alignment control register bank with SYSREF input conditioning
`timescale 1ns/1ps
`include "clk_align_consts.vh"
module clock_alignment_control_regs
(
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register access port from the serial configuration logic
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output wire [7:0] reg_rd_data,
  output wire reg_rd_valid,
  // Status from the windowing detector
  input wire [23:0] capture_position_status,
  // SYSREF input and conditioned alignment outputs
  input wire sysref_in,
  output wire sysref_level,
  output wire sysref_event,
  // Control fields toward the analog and clock path
  output wire align_processor_on,
  output wire align_receiver_on,
  output wire fine_window_step,
  output wire [3:0] capture_delay_tap,
  output wire main_clock_pecl_mode,
  output wire align_input_pecl_mode,
  output wire align_polarity_invert,
  output wire core_supply_quieting,
  output wire clock_supply_quieting
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Unmapped addresses fall to index 3, which no control register answers
  function [1:0] ctrl_index;
    input [7:0] addr;
    begin
      if (addr == `OFS_SYSREF_PATH_CONTROL)
        ctrl_index = 2'd0;
      else if (addr == `OFS_INPUT_MODE_CONTROL)
        ctrl_index = 2'd1;
      else if (addr == `OFS_SUPPLY_NOISE_CONTROL)
        ctrl_index = 2'd2;
      else
        ctrl_index = 2'd3;
    end
  endfunction

  function [7:0] ctrl_reset;
    input integer idx;
    begin
      if (idx == 0)
        ctrl_reset = `RST_SYSREF_PATH_CONTROL;
      else if (idx == 1)
        ctrl_reset = `RST_INPUT_MODE_CONTROL;
      else
        ctrl_reset = `RST_SUPPLY_NOISE_CONTROL;
    end
  endfunction

  wire [1:0] wr_index;
  wire [1:0] rd_index;
  wire [23:0] ctrl_flat;
  wire [7:0] path_ctrl;
  wire [7:0] mode_ctrl;
  wire [7:0] quiet_ctrl;

  assign wr_index = ctrl_index(reg_addr);
  assign rd_index = ctrl_index(reg_addr);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_ctrl
      ctrl_byte_reg
      #(
        .RESET_VAL(ctrl_reset(gi))
      )
      u_reg
      (
        .clk_sys(clk_sys),
        .srst(srst),
        // Reserved bits are stored as given; keeping them at default is up to software
        .wr_sel(reg_wr_en && (wr_index == gi)),
        .wr_data(reg_wr_data),
        .value(ctrl_flat[gi*8 +: 8])
      );
    end
  endgenerate

  assign path_ctrl = ctrl_flat[7:0];
  assign mode_ctrl = ctrl_flat[15:8];
  assign quiet_ctrl = ctrl_flat[23:16];

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign align_processor_on = path_ctrl[`BIT_PROCESSOR_ON];
  assign align_receiver_on = path_ctrl[`BIT_RECEIVER_ON];
  // Changes how both the status and the tap number are to be read
  assign fine_window_step = path_ctrl[`BIT_FINE_STEP];
  assign capture_delay_tap = path_ctrl[`TAP_MSB:`TAP_LSB];
  assign main_clock_pecl_mode = mode_ctrl[`BIT_MAIN_CLK_PECL];
  assign align_input_pecl_mode = mode_ctrl[`BIT_ALIGN_PECL];
  assign align_polarity_invert = mode_ctrl[`BIT_POL_INVERT];
  assign core_supply_quieting = quiet_ctrl[`BIT_CORE_QUIET];
  assign clock_supply_quieting = quiet_ctrl[`BIT_CLOCK_QUIET];

  // ----------------------------------------------------------------
  // SYSREF conditioning
  // ----------------------------------------------------------------
  // Level is registered once so the edge detector works from flops, not from the pin
  reg sysref_level_ff;
  reg sysref_prev_ff;
  reg sysref_event_ff;
  reg nxt_sysref_level;
  reg nxt_sysref_event;

  always @*
  begin
    nxt_sysref_level = 1'b0;
    if (align_receiver_on)
    begin
      nxt_sysref_level = sysref_in ^ align_polarity_invert;
    end
  end

  always @*
  begin
    // A disabled receiver holds the level low, so an early processor sees no event
    nxt_sysref_event = align_processor_on && sysref_level_ff && !sysref_prev_ff;
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      sysref_level_ff <= 1'b0;
      sysref_prev_ff <= 1'b0;
      sysref_event_ff <= 1'b0;
    end
    else
    begin
      sysref_level_ff <= nxt_sysref_level;
      sysref_prev_ff <= sysref_level_ff;
      sysref_event_ff <= nxt_sysref_event;
    end
  end

  assign sysref_level = sysref_level_ff;
  assign sysref_event = sysref_event_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Status bytes are taken live at each read; a moving value can tear across the three
  reg [7:0] rd_data_ff;
  reg rd_valid_ff;
  reg [7:0] nxt_rd_data;

  always @*
  begin
    nxt_rd_data = rd_data_ff;
    if (reg_rd_en)
    begin
      if (rd_index != 2'd3)
        nxt_rd_data = ctrl_flat[rd_index*8 +: 8];
      else if (reg_addr == `OFS_CAPTURE_POS_LO)
        nxt_rd_data = capture_position_status[7:0];
      else if (reg_addr == `OFS_CAPTURE_POS_MID)
        nxt_rd_data = capture_position_status[15:8];
      else if (reg_addr == `OFS_CAPTURE_POS_HI)
        nxt_rd_data = capture_position_status[23:16];
      else
        nxt_rd_data = `RST_UNMAPPED_READ;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= reg_rd_en;
    end
  end

  // Status is sampled on the read cycle; software reads it before picking a tap
  assign reg_rd_data = rd_data_ff;
  assign reg_rd_valid = rd_valid_ff;

endmodule // clock_alignment_control_regs

// *** verif/clk_align_chk_asserts.sv ***
// Assertion checker for the clock alignment control register bank
`timescale 1ns/1ps
module clk_align_chk
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic [23:0] capture_position_status,
  // SYSREF path
  input wire logic sysref_in,
  input wire logic sysref_level,
  input wire logic sysref_event,
  // Control fields
  input wire logic align_processor_on,
  input wire logic align_receiver_on,
  input wire logic fine_window_step,
  input wire logic [3:0] capture_delay_tap,
  input wire logic main_clock_pecl_mode,
  input wire logic align_input_pecl_mode,
  input wire logic align_polarity_invert,
  input wire logic core_supply_quieting,
  input wire logic clock_supply_quieting
);
  default clocking dflt @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  path_wr_a: assert property (
    reg_wr_en && reg_addr == 8'h29 |=> {align_processor_on, align_receiver_on, fine_window_step,
    capture_delay_tap} == $past(reg_wr_data[6:0])) else $error("path control write lost");
  tap_hold_a: assert property (
    !(reg_wr_en && reg_addr == 8'h29) |=> $stable(capture_delay_tap))
    else $error("delay tap changed without a write");
  mode_wr_a: assert property (
    reg_wr_en && reg_addr == 8'h2a |=> {main_clock_pecl_mode, align_input_pecl_mode,
    align_polarity_invert} == $past(reg_wr_data[2:0])) else $error("input mode write lost");
  quiet_wr_a: assert property (
    reg_wr_en && reg_addr == 8'h2b |=> core_supply_quieting == $past(reg_wr_data[2])
    && clock_supply_quieting == $past(reg_wr_data[0])) else $error("quieting write lost");
  rd_valid_a: assert property (
    1'b1 |=> reg_rd_valid == $past(reg_rd_en)) else $error("read valid misplaced");
  status_rd_a: assert property (
    reg_rd_en && reg_addr == 8'h2c |=> reg_rd_data == $past(capture_position_status[7:0]))
    else $error("status low byte wrong");
  sysref_level_a: assert property (
    1'b1 |=> sysref_level == $past(align_receiver_on && (sysref_in ^ align_polarity_invert)))
    else $error("sysref level wrong");
  sysref_event_a: assert property (
    sysref_event |-> $past(sysref_level) && !$past(sysref_level, 2))
    else $error("event without level rise");
  reset_fields_a: assert property (
    $fell(srst) |-> {align_processor_on, align_receiver_on, fine_window_step, capture_delay_tap,
    align_polarity_invert, core_supply_quieting, clock_supply_quieting} == 10'h000)
    else $error("field not cleared by reset");
endmodule // clk_align_chk

bind clock_alignment_control_regs clk_align_chk u_chk (.*);

// *** verif/clock_alignment_control_regs_tb.sv ***
// Testbench for the clock alignment control register bank
`timescale 1ns/1ps
module clock_alignment_control_regs_tb;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr_en = 1'b0;
  reg [7:0] reg_wr_data = 8'h00;
  reg reg_rd_en = 1'b0;
  reg [23:0] capture_position_status = 24'h5a3cc1;
  reg sysref_in = 1'b0;
  wire [7:0] reg_rd_data;
  wire reg_rd_valid;
  wire sysref_level;
  wire sysref_event;
  wire [11:0] f;
  integer errors = 0;
  integer compares = 0;
  integer cyc = 0;

  clock_alignment_control_regs dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .capture_position_status(capture_position_status), .sysref_in(sysref_in),
    .sysref_level(sysref_level), .sysref_event(sysref_event), .align_processor_on(f[11]),
    .align_receiver_on(f[10]), .fine_window_step(f[9]), .capture_delay_tap(f[8:5]),
    .main_clock_pecl_mode(f[4]), .align_input_pecl_mode(f[3]), .align_polarity_invert(f[2]),
    .core_supply_quieting(f[1]), .clock_supply_quieting(f[0]));

  always #10 clk_sys = ~clk_sys;

  // Generous ceiling: the whole sequence needs well under 200 cycles
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      errors = errors + 1;
      report_and_stop;
    end
  end

  task report_and_stop;
  begin
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  task chk(input [63:0] nm, input [23:0] exp, input [23:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  // Idle cycle after each access so a strobe is never raised in the step it fell
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    @(negedge clk_sys);
  end
  endtask

  task rd(input [7:0] a, input [7:0] e);
  begin
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    chk("rd_valid", 24'h1, {23'h0, reg_rd_valid});
    chk("rd_data", {16'h0, e}, {16'h0, reg_rd_data});
    @(negedge clk_sys);
  end
  endtask

  task sp(input lv, input ev);
  begin
    sysref_in = 1'b1;
    @(negedge clk_sys);
    chk("level", {23'h0, lv}, {23'h0, sysref_level});
    @(negedge clk_sys);
    chk("event", {23'h0, ev}, {23'h0, sysref_event});
    sysref_in = 1'b0;
    repeat (2) @(negedge clk_sys);
  end
  endtask

  initial
  begin
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    chk("fields", 24'h0, {12'h0, f});
    rd(8'h29, 8'h80);
    rd(8'h2a, 8'h00);
    rd(8'h2b, 8'h10);
    // Status is read before any tap is chosen
    rd(8'h2c, 8'hc1);
    rd(8'h2d, 8'h3c);
    rd(8'h2e, 8'h5a);
    // Bit 7 of path control is always written back as one
    wr(8'h29, 8'ha0);
    chk("fields", 24'h400, {12'h0, f});
    wr(8'h29, 8'hf5);
    chk("fields", 24'hea0, {12'h0, f});
    rd(8'h29, 8'hf5);
    wr(8'h2a, 8'h07);
    chk("fields", 24'hebc, {12'h0, f});
    wr(8'h2b, 8'h15);
    chk("fields", 24'hebf, {12'h0, f});
    rd(8'h2a, 8'h07);
    rd(8'h2b, 8'h15);
    wr(8'h28, 8'hff);
    chk("fields", 24'hebf, {12'h0, f});
    rd(8'h28, 8'h00);
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'hc1);
    wr(8'h2a, 8'h00);
    sp(1'b1, 1'b1);
    wr(8'h2a, 8'h01);
    chk("level", 24'h1, {23'h0, sysref_level});
    wr(8'h2a, 8'h00);
    // Receiver and processor go off together, then the receiver alone comes back on
    wr(8'h29, 8'h80);
    sp(1'b0, 1'b0);
    wr(8'h29, 8'ha0);
    sp(1'b1, 1'b0);
    report_and_stop;
  end
endmodule // clock_alignment_control_regs_tb
